// file: verification/dpms_chk.sv
// Port-level assertions for the debug port mode switch
// Assumes binding onto dpms_top; everything runs on CLK_I
`timescale 1ns/100ps
module dpms_chk (
    input wire logic                    CLK_I,
    input wire logic                    RST_B_I,
    input wire dpms_pkg::dpms_link_t    LINK_I,
    input wire logic                    CHIP_RST_B_I,
    input wire logic                    ERASE_DONE_I,
    input wire logic                    TDO_O,
    input wire logic                    TDO_OE_O,
    input wire dpms_pkg::dpms_pin_cfg_t PIN_CFG_O,
    input wire logic                    SWD_ACTIVE_O,
    input wire logic                    JTAG_ACTIVE_O,
    input wire logic                    SWD_LINE_RESET_O,
    input wire logic                    MASS_ERASE_O,
    input wire logic                    NV_RESTORE_O
);
    import dpms_pkg::*;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // ********
    // Erase then restore, in that order
    // ********
    sequence erase_done_s;
        MASS_ERASE_O && ERASE_DONE_I;
    endsequence
    sequence restore_s;
        !MASS_ERASE_O && NV_RESTORE_O ##1 !NV_RESTORE_O;
    endsequence
    reset_pins_a: assert property ($rose(RST_B_I) |-> PIN_CFG_O == 15'h7FFF)
        else $error("pin config not all set after reset");
    reset_mode_a: assert property ($rose(RST_B_I) |-> JTAG_ACTIVE_O && !SWD_ACTIVE_O)
        else $error("protocol not scan after reset");
    mode_excl_a: assert property (SWD_ACTIVE_O != JTAG_ACTIVE_O)
        else $error("both or neither protocol active");
    line_reset_mode_a: assert property (SWD_LINE_RESET_O |-> SWD_ACTIVE_O)
        else $error("line reset outside serial-wire mode");
    tdo_drive_a: assert property (TDO_OE_O |-> JTAG_ACTIVE_O && PIN_CFG_O.afsel[3])
        else $error("data out driven outside scan use");
    tdo_edge_a: assert property ($changed(TDO_O) |-> !$past(LINK_I.tck) || !$past(LINK_I.tck, 2))
        else $error("data out changed away from falling clock");
    erase_start_a: assert property ($rose(MASS_ERASE_O) |-> !$past(CHIP_RST_B_I, 4))
        else $error("erase started without chip reset held");
    erase_hold_a: assert property (MASS_ERASE_O && !ERASE_DONE_I |=> MASS_ERASE_O)
        else $error("erase request dropped early");
    erase_clear_a: assert property (erase_done_s |=> restore_s)
        else $error("restore pulse wrong after erase done");
    restore_cause_a: assert property ($rose(NV_RESTORE_O) |-> $past(MASS_ERASE_O && ERASE_DONE_I))
        else $error("restore without finished erase");
endmodule

// file: verification/dpms_probe.sv
// Debug probe model driving test clock, mode and data lines
// Assumes one caller at a time; lines rest high, the pull-up level
`timescale 1ns/100ps
module dpms_probe (
    input  wire logic            clk_i,
    output dpms_pkg::dpms_link_t link_o,
    output logic                 look_o
);
    import dpms_pkg::*;
    // Clock parks high between bits so no stray edges reach the port
    initial begin
        link_o = '1;
        look_o = 1'b0;
    end
    // One test-clock bit of eight cycles; look marks the last cycle
    task automatic clk_bit(input logic tms, input logic tdi, input logic look);
        @(posedge clk_i);
        look_o     <= 1'b0;
        link_o.tck <= 1'b0;
        link_o.tms <= tms;
        link_o.tdi <= tdi;
        repeat (4) @(posedge clk_i);
        link_o.tck <= 1'b1;
        repeat (3) @(posedge clk_i);
        look_o     <= look;
    endtask
    task automatic switch_seq(input logic [15:0] code, input int lead, input int trail);
        repeat (lead) clk_bit(1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 16; i++) clk_bit(code[i], 1'b1, 1'b0);
        repeat (trail) clk_bit(1'b1, 1'b1, 1'b0);
    endtask
endmodule

// file: verification/dpms_top_tb.sv
// Self-checking bench for the debug port mode switch
// Assumes the probe model owns the link; register port driven here
`timescale 1ns/100ps
`include "dpms_defines.svh"
module dpms_top_tb;
    import dpms_pkg::*;
    logic          clk, rst_b, chip_rst_b, erase_done, wr, rd, look;
    logic          rd_seen = 1'b0;
    logic          tdo, tdo_oe, swd, jtag, line_rst, erase, nv_rst;
    logic [7:0]    addr;
    logic [31:0]   wdata, rdata;
    logic [4:0]    m;
    dpms_link_t    link;
    dpms_pin_cfg_t pin_cfg;
    logic [31:0]   rd_q[$];
    logic          tdo_q[$];
    int            fails = 0, cmp_count = 0, cycles = 0;
    logic [7:0]    adr_t[6] = '{`DPMS_ADDR_AFSEL, `DPMS_ADDR_DEN, `DPMS_ADDR_PUR,
                                `DPMS_ADDR_LOCK, `DPMS_ADDR_COMMIT, 8'h20};
    logic [31:0]   exp_t[6] = '{32'h1F, 32'h1F, 32'h1F, 32'h1, 32'h0, 32'h0};
    dpms_top i_dpms_top (.CLK_I(clk), .RST_B_I(rst_b), .LINK_I(link), .CHIP_RST_B_I(chip_rst_b),
        .ERASE_DONE_I(erase_done), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .PIN_CFG_O(pin_cfg),
        .SWD_ACTIVE_O(swd), .JTAG_ACTIVE_O(jtag), .SWD_LINE_RESET_O(line_rst),
        .MASS_ERASE_O(erase), .NV_RESTORE_O(nv_rst));
    dpms_probe i_dpms_probe (.clk_i(clk), .link_o(link), .look_o(look));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ********
    // Checking and closing
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Results are matched against notes in the order they were made
    always @(posedge clk) begin
        rd_seen <= rd;
        cycles  <= cycles + 1;
        if (rd_seen === 1'b1) check(rdata, rd_q.pop_front());
        if (look === 1'b1) check(32'(tdo), 32'(tdo_q.pop_front()));
        if (look === 1'b1) check(32'(tdo_oe), 32'h1);
        if (cycles == 30000) begin
            fails++;
            print_verdict();
        end
    end
    // ********
    // Drivers
    // ********
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        rd_q.push_back(e);
        @(posedge clk);
        rd   <= 1'b0;
    endtask
    // Reset the TAP, enter data shift, push 64 bits through the ID chain
    task automatic scan_id(input logic [31:0] din);
        logic [31:0] id;
        logic [3:0]  path;
        id   = `DPMS_IDCODE;
        path = 4'h2;
        repeat (5) i_dpms_probe.clk_bit(1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) i_dpms_probe.clk_bit(path[i], 1'b1, 1'b0);
        for (int i = 0; i < 64; i++) begin
            tdo_q.push_back(i < 32 ? id[i] : din[i - 32]);
            i_dpms_probe.clk_bit(i == 63, i < 32 ? din[i] : 1'b1, 1'b1);
        end
        i_dpms_probe.clk_bit(1'b1, 1'b1, 1'b0);
        i_dpms_probe.clk_bit(1'b0, 1'b1, 1'b0);
    endtask
    task automatic mode_chk(input logic s, input logic lr);
        repeat (20) @(posedge clk);
        check(32'(swd), 32'(s));
        check(32'(jtag), 32'(!s));
        check(32'(line_rst), 32'(lr));
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        rst_b      = 1'b0;
        chip_rst_b = 1'b1;
        erase_done = 1'b0;
        wr         = 1'b0;
        rd         = 1'b0;
        addr       = 8'h00;
        wdata      = 32'h0;
        void'($urandom(32'hDF9CCCC6));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        check(32'(pin_cfg), 32'h7FFF);
        check(32'(jtag), 32'h1);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 6; i++) reg_rd(adr_t[i], exp_t[i]);
        scan_id($urandom);
        reg_wr(`DPMS_ADDR_AFSEL, 32'h0);
        reg_rd(`DPMS_ADDR_AFSEL, 32'h1F);
        reg_wr(`DPMS_ADDR_LOCK, `DPMS_LOCK_KEY);
        m = 5'($urandom) | 5'h01;
        reg_wr(`DPMS_ADDR_COMMIT, {27'h0, m});
        reg_wr(`DPMS_ADDR_AFSEL, 32'h0);
        reg_rd(`DPMS_ADDR_AFSEL, {27'h0, ~m});
        check(32'(pin_cfg.afsel), {27'h0, ~m});
        reg_wr(`DPMS_ADDR_COMMIT, 32'h1F);
        reg_wr(`DPMS_ADDR_AFSEL, 32'h1F);
        reg_wr(`DPMS_ADDR_LOCK, 32'h0);
        reg_rd(`DPMS_ADDR_LOCK, 32'h1);
        scan_id($urandom);
        // Return code is refused while already in scan mode
        i_dpms_probe.switch_seq(`DPMS_TO_JTAG, 50, 5);
        mode_chk(1'b0, 1'b0);
        // A zero first, so exactly fifty ones lead the code
        i_dpms_probe.clk_bit(1'b0, 1'b1, 1'b0);
        i_dpms_probe.switch_seq(`DPMS_TO_SWD, 50, 50);
        mode_chk(1'b1, 1'b1);
        reg_rd(`DPMS_ADDR_STATUS, 32'h1);
        i_dpms_probe.switch_seq(`DPMS_TO_JTAG, 50, 5);
        mode_chk(1'b0, 1'b0);
        i_dpms_probe.switch_seq(`DPMS_PRE_TMS, 5, 0);
        mode_chk(1'b1, 1'b0);
        i_dpms_probe.switch_seq(`DPMS_TO_JTAG, 50, 5);
        mode_chk(1'b0, 1'b0);
        reg_wr(`DPMS_ADDR_DEN, 32'h0);
        @(posedge clk);
        check(32'(pin_cfg.den), 32'h0);
        chip_rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        check(32'(pin_cfg), 32'h7FFF);
        for (int i = 0; i < 10; i++) begin
            i_dpms_probe.switch_seq(i[0] ? `DPMS_TO_JTAG : `DPMS_TO_SWD, 50, 0);
            repeat (20) @(posedge clk);
            check(32'(erase), 32'(i == 9));
            check(32'(nv_rst), 32'h0);
        end
        erase_done <= 1'b1;
        @(posedge clk);
        erase_done <= 1'b0;
        #1;
        check(32'(nv_rst), 32'h1);
        check(32'(erase), 32'h0);
        @(posedge clk);
        chip_rst_b <= 1'b1;
        repeat (20) @(posedge clk);
        check(32'(jtag), 32'h1);
        print_verdict();
    end
endmodule
bind dpms_top dpms_chk i_dpms_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .LINK_I(LINK_I),
    .CHIP_RST_B_I(CHIP_RST_B_I), .ERASE_DONE_I(ERASE_DONE_I), .TDO_O(TDO_O),
    .TDO_OE_O(TDO_OE_O), .PIN_CFG_O(PIN_CFG_O), .SWD_ACTIVE_O(SWD_ACTIVE_O),
    .JTAG_ACTIVE_O(JTAG_ACTIVE_O), .SWD_LINE_RESET_O(SWD_LINE_RESET_O),
    .MASS_ERASE_O(MASS_ERASE_O), .NV_RESTORE_O(NV_RESTORE_O));

// file: verilog/dpms_defines.svh
// Constants of the debug port mode switch: offsets, fields, codes, counts
// Assumes inclusion by bare name from every design file that needs them
`ifndef DPMS_DEFINES_SVH
`define DPMS_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define DPMS_ADDR_AFSEL   8'h00
`define DPMS_ADDR_DEN     8'h04
`define DPMS_ADDR_PUR     8'h08
`define DPMS_ADDR_LOCK    8'h0C
`define DPMS_ADDR_COMMIT  8'h10
`define DPMS_ADDR_STATUS  8'h14
`define DPMS_LOCK_KEY     32'h4C4F_434B
`define DPMS_PIN_RESET    5'h1F
`define DPMS_COMMIT_RESET 5'h00

// ****************************************
// Pin bit positions
// ****************************************
`define DPMS_PIN_TCK  0
`define DPMS_PIN_TMS  1
`define DPMS_PIN_TDI  2
`define DPMS_PIN_TDO  3
`define DPMS_PIN_TRST 4

// ****************************************
// Scan and switch codes
// ****************************************
`define DPMS_IR_CAPTURE 4'h1
`define DPMS_IR_IDCODE  4'hE
// Arbitrary identification value, bit 0 set as scan convention wants
`define DPMS_IDCODE     32'h1234_5671
`define DPMS_TO_SWD     16'hE79E
`define DPMS_TO_JTAG    16'hE73C
// Mode-line bits of the preamble path, bit 0 first
`define DPMS_PRE_TMS    16'hE79E
`define DPMS_ONES_SAT   6'h32
`define DPMS_CODE_LAST  4'hF
`define DPMS_RECOVER_N  4'hA

`endif

// file: verilog/dpms_pkg.sv
// Types shared by the debug port mode switch modules
// Assumes nothing beyond a SystemVerilog compiler
package dpms_pkg;
    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
    } dpms_tap_t;
    typedef enum logic {MODE_JTAG, MODE_SWD} dpms_mode_t;
    typedef struct packed {
        logic trst_b;
        logic tdi;
        logic tms;
        logic tck;
    } dpms_link_t;
    typedef struct packed {
        logic [4:0] den;
        logic [4:0] pur;
        logic [4:0] afsel;
    } dpms_pin_cfg_t;
endpackage

// file: verilog/dpms_scan_chain.sv
// Serial scan chain with parallel holding register
// Assumes step_i is a one-cycle pulse on each sampled test-clock rise
`timescale 1ns/100ps
module dpms_scan_chain #(
    parameter int           W    = 4,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         step_i,
    input  wire logic         capture_i,
    input  wire logic         shift_i,
    input  wire logic         update_i,
    input  wire logic         init_i,
    input  wire logic         tdi_i,
    input  wire logic [W-1:0] cap_data_i,
    output logic              so_o,
    output logic [W-1:0]      par_o
);
    logic [W-1:0] sr_reg;

    assign so_o = sr_reg[0];

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sr_reg <= '0;
        end else if (step_i && capture_i) begin
            sr_reg <= cap_data_i;
        end else if (step_i && shift_i) begin
            sr_reg <= {tdi_i, sr_reg[W-1:1]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i || init_i) begin
            par_o <= INIT;
        end else if (step_i && update_i) begin
            par_o <= sr_reg;
        end
    end
endmodule

// file: verilog/dpms_sync.sv
// Two-flop synchroniser for a group of pin levels
// Assumes inputs asynchronous to clk_i; INIT is the idle pin level
`timescale 1ns/100ps
module dpms_sync #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic [W-1:0]      q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_reg <= INIT;
            q_o      <= INIT;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule

// file: verilog/dpms_top.sv
// Debug port top: pin ownership, scan chains, protocol switch, recovery
// Assumes probe pins are asynchronous to CLK_I; register port on CLK_I
`timescale 1ns/100ps
`include "dpms_defines.svh"
module dpms_top (
    input  wire logic                  CLK_I,
    input  wire logic                  RST_B_I,
    input  wire dpms_pkg::dpms_link_t  LINK_I,
    input  wire logic                  CHIP_RST_B_I,
    input  wire logic                  ERASE_DONE_I,
    input  wire logic [7:0]            ADDR_I,
    input  wire logic [31:0]           WDATA_I,
    input  wire logic                  WR_I,
    input  wire logic                  RD_I,
    output logic [31:0]                RDATA_O,
    output logic                       TDO_O,
    output logic                       TDO_OE_O,
    output dpms_pkg::dpms_pin_cfg_t    PIN_CFG_O,
    output logic                       SWD_ACTIVE_O,
    output logic                       JTAG_ACTIVE_O,
    output logic                       SWD_LINE_RESET_O,
    output logic                       MASS_ERASE_O,
    output logic                       NV_RESTORE_O
);
    import dpms_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic [4:0]    sync_q;
    dpms_link_t    lnk;
    logic          chip_held;
    logic          tck_d_reg;
    logic          rise;
    logic          fall;
    dpms_tap_t     tap_reg;
    dpms_tap_t     tap_next;
    dpms_mode_t    mode_reg;
    dpms_pin_cfg_t cfg_reg;
    logic          locked_reg;
    logic [4:0]    commit_reg;
    logic [3:0]    ir_par;
    logic          ir_so;
    logic          id_so;
    logic          byp_reg;
    logic          sel_id;
    logic [5:0]    ones_reg;
    logic [15:0]   sw_sr_reg;
    logic [15:0]   sw_sr_next;
    logic          armed_reg;
    logic [3:0]    post_reg;
    logic          code_hit;
    logic [3:0]    pre_idx_reg;
    logic          pre_ok;
    logic [15:0]   pre_pat;
    logic          pre_hit;
    logic [3:0]    rec_cnt_reg;
    logic          erase_wait_reg;

    // ****************************************
    // Pin sampling
    // ****************************************
    dpms_sync #(
        .W    (5),
        .INIT (5'h1F)
    ) u_sync (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .d_i     ({CHIP_RST_B_I, LINK_I}),
        .q_o     (sync_q)
    );

    assign chip_held = ~sync_q[4];

    // A pin handed to general-purpose use is seen as its pull-up level
    always_comb begin
        lnk = dpms_link_t'(sync_q[3:0]);
        if (!cfg_reg.afsel[`DPMS_PIN_TCK]) begin
            lnk.tck = 1'b1;
        end
        if (!cfg_reg.afsel[`DPMS_PIN_TMS]) begin
            lnk.tms = 1'b1;
        end
        if (!cfg_reg.afsel[`DPMS_PIN_TDI]) begin
            lnk.tdi = 1'b1;
        end
        if (!cfg_reg.afsel[`DPMS_PIN_TRST]) begin
            lnk.trst_b = 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            tck_d_reg <= 1'b1;
        end else begin
            tck_d_reg <= lnk.tck;
        end
    end

    assign rise = lnk.tck & ~tck_d_reg;
    assign fall = ~lnk.tck & tck_d_reg;

    // ****************************************
    // TAP controller
    // ****************************************
    always_comb begin
        unique case (tap_reg)
            TAP_TLR:    tap_next = lnk.tms ? TAP_TLR    : TAP_RTI;
            TAP_RTI:    tap_next = lnk.tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_next = lnk.tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = lnk.tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_next = lnk.tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = lnk.tms ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  tap_next = lnk.tms ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tap_next = lnk.tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = lnk.tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_next = lnk.tms ? TAP_TLR    : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = lnk.tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_next = lnk.tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = lnk.tms ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  tap_next = lnk.tms ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tap_next = lnk.tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = lnk.tms ? TAP_SEL_DR : TAP_RTI;
        endcase
    end

    // Scan engine sits in reset whenever serial-wire owns the port
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || !lnk.trst_b || mode_reg == MODE_SWD) begin
            tap_reg <= TAP_TLR;
        end else if (rise) begin
            tap_reg <= tap_next;
        end
    end

    // ****************************************
    // Scan chains
    // ****************************************
    dpms_scan_chain #(
        .W    (4),
        .INIT (`DPMS_IR_IDCODE)
    ) u_ir (
        .clk_i      (CLK_I),
        .rst_b_i    (RST_B_I),
        .step_i     (rise),
        .capture_i  (tap_reg == TAP_CAP_IR),
        .shift_i    (tap_reg == TAP_SH_IR),
        .update_i   (tap_reg == TAP_UPD_IR),
        .init_i     (tap_reg == TAP_TLR),
        .tdi_i      (lnk.tdi),
        .cap_data_i (`DPMS_IR_CAPTURE),
        .so_o       (ir_so),
        .par_o      (ir_par)
    );

    // Only identification and bypass are modelled; other codes bypass
    assign sel_id = (ir_par == `DPMS_IR_IDCODE);

    dpms_scan_chain #(
        .W    (32),
        .INIT (32'h0000_0000)
    ) u_id (
        .clk_i      (CLK_I),
        .rst_b_i    (RST_B_I),
        .step_i     (rise),
        .capture_i  (tap_reg == TAP_CAP_DR && sel_id),
        .shift_i    (tap_reg == TAP_SH_DR && sel_id),
        .update_i   (1'b0),
        .init_i     (1'b0),
        .tdi_i      (lnk.tdi),
        .cap_data_i (`DPMS_IDCODE),
        .so_o       (id_so),
        .par_o      ()
    );

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            byp_reg <= 1'b0;
        end else if (rise && tap_reg == TAP_CAP_DR) begin
            byp_reg <= 1'b0;
        end else if (rise && tap_reg == TAP_SH_DR) begin
            byp_reg <= lnk.tdi;
        end
    end

    // Output changes on the falling test clock so the probe samples it clean
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            TDO_O    <= 1'b0;
            TDO_OE_O <= 1'b0;
        end else if (fall) begin
            TDO_O    <= (tap_reg == TAP_SH_IR) ? ir_so : (sel_id ? id_so : byp_reg);
            TDO_OE_O <= cfg_reg.afsel[`DPMS_PIN_TDO] &&
                        (tap_reg == TAP_SH_IR || tap_reg == TAP_SH_DR);
        end
    end

    // ****************************************
    // Switch code detector
    // ****************************************
    assign sw_sr_next = {lnk.tms, sw_sr_reg[15:1]};
    assign code_hit = rise && armed_reg && post_reg == `DPMS_CODE_LAST &&
                      ((mode_reg == MODE_JTAG && sw_sr_next == `DPMS_TO_SWD) ||
                       (mode_reg == MODE_SWD && sw_sr_next == `DPMS_TO_JTAG));

    // A code counts only after a full run of ones; trailing ones not needed
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ones_reg  <= 6'h00;
            sw_sr_reg <= 16'h0000;
            armed_reg <= 1'b0;
            post_reg  <= 4'h0;
        end else if (rise) begin
            sw_sr_reg <= sw_sr_next;
            if (!lnk.tms) begin
                ones_reg <= 6'h00;
            end else if (ones_reg != `DPMS_ONES_SAT) begin
                ones_reg <= ones_reg + 6'h01;
            end
            if (lnk.tms && ones_reg >= `DPMS_ONES_SAT - 6'h01) begin
                armed_reg <= 1'b1;
                post_reg  <= 4'h0;
            end else if (armed_reg) begin
                post_reg <= post_reg + 4'h1;
                if (post_reg == `DPMS_CODE_LAST) begin
                    armed_reg <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Preamble detector
    // ****************************************
    assign pre_pat = `DPMS_PRE_TMS;
    assign pre_ok  = (lnk.tms == pre_pat[pre_idx_reg]) &&
                     (pre_idx_reg != 4'h0 || tap_reg == TAP_TLR);
    assign pre_hit = rise && mode_reg == MODE_JTAG && pre_ok && pre_idx_reg == 4'hF;

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || mode_reg == MODE_SWD) begin
            pre_idx_reg <= 4'h0;
        end else if (rise) begin
            pre_idx_reg <= pre_ok ? pre_idx_reg + 4'h1 : 4'h0;
        end
    end

    // ****************************************
    // Protocol selector
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            mode_reg <= MODE_JTAG;
        end else if (code_hit) begin
            mode_reg <= (mode_reg == MODE_JTAG) ? MODE_SWD : MODE_JTAG;
        end else if (pre_hit) begin
            mode_reg <= MODE_SWD;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            SWD_ACTIVE_O     <= 1'b0;
            JTAG_ACTIVE_O    <= 1'b1;
            SWD_LINE_RESET_O <= 1'b0;
        end else begin
            SWD_ACTIVE_O     <= (mode_reg == MODE_SWD);
            JTAG_ACTIVE_O    <= (mode_reg == MODE_JTAG);
            SWD_LINE_RESET_O <= (mode_reg == MODE_SWD) && ones_reg == `DPMS_ONES_SAT;
        end
    end

    // ****************************************
    // Locked-part recovery
    // ****************************************
    // Count resets if chip reset drops before the tenth switch
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || !chip_held) begin
            rec_cnt_reg <= 4'h0;
        end else if (code_hit) begin
            rec_cnt_reg <= (rec_cnt_reg == `DPMS_RECOVER_N - 4'h1) ? 4'h0 :
                           rec_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            MASS_ERASE_O   <= 1'b0;
            erase_wait_reg <= 1'b0;
            NV_RESTORE_O   <= 1'b0;
        end else begin
            NV_RESTORE_O <= 1'b0;
            if (chip_held && code_hit && rec_cnt_reg == `DPMS_RECOVER_N - 4'h1) begin
                MASS_ERASE_O   <= 1'b1;
                erase_wait_reg <= 1'b1;
            end else if (erase_wait_reg && ERASE_DONE_I) begin
                MASS_ERASE_O   <= 1'b0;
                erase_wait_reg <= 1'b0;
                NV_RESTORE_O   <= 1'b1;
            end
        end
    end

    // ****************************************
    // Pin configuration registers
    // ****************************************
    assign PIN_CFG_O = cfg_reg;

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || chip_held) begin
            cfg_reg.den   <= `DPMS_PIN_RESET;
            cfg_reg.pur   <= `DPMS_PIN_RESET;
            cfg_reg.afsel <= `DPMS_PIN_RESET;
        end else if (WR_I) begin
            if (ADDR_I == `DPMS_ADDR_DEN) begin
                cfg_reg.den <= WDATA_I[4:0];
            end
            if (ADDR_I == `DPMS_ADDR_PUR) begin
                cfg_reg.pur <= WDATA_I[4:0];
            end
            if (ADDR_I == `DPMS_ADDR_AFSEL && !locked_reg) begin
                cfg_reg.afsel <= (WDATA_I[4:0] & commit_reg) |
                                 (cfg_reg.afsel & ~commit_reg);
            end
        end
    end

    // Commit changes only while unlocked writes reach it
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || chip_held) begin
            locked_reg <= 1'b1;
            commit_reg <= `DPMS_COMMIT_RESET;
        end else if (WR_I) begin
            if (ADDR_I == `DPMS_ADDR_LOCK) begin
                locked_reg <= (WDATA_I != `DPMS_LOCK_KEY);
            end
            if (ADDR_I == `DPMS_ADDR_COMMIT && !locked_reg) begin
                commit_reg <= WDATA_I[4:0];
            end
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || !RD_I) begin
            RDATA_O <= 32'h0000_0000;
        end else begin
            unique case (ADDR_I)
                `DPMS_ADDR_AFSEL:  RDATA_O <= {27'h0, cfg_reg.afsel};
                `DPMS_ADDR_DEN:    RDATA_O <= {27'h0, cfg_reg.den};
                `DPMS_ADDR_PUR:    RDATA_O <= {27'h0, cfg_reg.pur};
                `DPMS_ADDR_LOCK:   RDATA_O <= {31'h0, locked_reg};
                `DPMS_ADDR_COMMIT: RDATA_O <= {27'h0, commit_reg};
                `DPMS_ADDR_STATUS: RDATA_O <= {16'h0, rec_cnt_reg, 3'h0, MASS_ERASE_O,
                                               tap_reg, 3'h0, mode_reg};
                default:           RDATA_O <= 32'h0000_0000;
            endcase
        end
    end
endmodule
